// File: logic/host_fifo_consts.svh
`ifndef HOST_FIFO_CONSTS_SVH
`define HOST_FIFO_CONSTS_SVH

`define FIFO_DEPTH      64
`define LEN_UNIT_SHIFT  2
`define LEN_NO_LIMIT    9'h100
`define CRC_PRESET_0    16'h0000
`define CRC_PRESET_1    16'h6363
`define CRC_PRESET_2    16'ha671
`define CRC_PRESET_3    16'hffff
`define CRC_POLY_MSB    16'h1021
`define CRC_POLY_LSB    16'h8408
`define RX_STS_OK       8'h00
`define RX_STS_ERR      8'h01
`define RD_EMPTY_VALUE  8'h00

`endif

// File: logic/host_fifo_pkg.sv
package host_fifo_pkg;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic       err;
    logic [7:0] data;
  } rx_byte_t;

  typedef struct packed {
    logic       start;
    logic [1:0] startSel;
    logic       msbOrder;
  } crc_cfg_t;

  typedef struct packed {
    logic [5:0] minLenQuads;
    logic [5:0] maxLenQuads;
  } len_filter_t;

  typedef enum logic [0:0] {
    CRC_IDLE = 1'b0,
    CRC_RUN  = 1'b1
  } crc_state_t;

endpackage

// File: logic/host_fifo_with_crc_and_length_filter.sv
`timescale 1ns/1ps
`include "host_fifo_consts.svh"
module host_fifo_with_crc_and_length_filter
  import host_fifo_pkg::*;
#(
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          hostWrStb,
  input  wire logic [7:0]    hostWrData,
  input  wire logic          hostRdStb,
  output logic [7:0]         hostRdData,
  input  wire logic          buffer_flush,
  input  wire logic [5:0]    watermark,
  input  wire logic          near_empty_irq_en,
  input  wire logic          near_full_irq_en,
  input  wire logic          rxEnable,
  input  wire logic          multi_packet_rx,
  input  wire len_filter_t   lenFilter,
  input  wire rx_byte_t      rxIn,
  output logic               rxReady,
  input  wire crc_cfg_t      crcCfg,
  input  wire logic          crcIrqClr,
  output logic [6:0]         stored_byte_count,
  output logic               buffer_overflow_err,
  output logic               near_full_flag,
  output logic               near_empty_flag,
  output logic               alertIrq,
  output logic [7:0]         crcResultHi,
  output logic [7:0]         crcResultLo,
  output logic               crc_done,
  output logic               crc_done_irq,
  output logic               crcBusy
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [7:0]    mem [DEPTH];
  logic [AW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [CW-1:0] count_r, count_nxt;
  logic          ovf_r, ovf_nxt;
  logic          nearFull_r, nearFull_nxt, nearEmpty_r, nearEmpty_nxt;
  logic          irq_r, irq_nxt;
  logic [7:0]    rdData_r, rdData_nxt;
  logic          inPkt_r, inPkt_nxt, drop_r, drop_nxt;
  logic          pktErr_r, pktErr_nxt;
  logic          stsPend_r, stsPend_nxt;
  logic [7:0]    stsByte_r, stsByte_nxt;
  logic          rxDone_r, rxDone_nxt, rxReady_r, rxReady_nxt;
  crc_state_t    crcState_r, crcState_nxt;
  logic [15:0]   crc_r, crc_nxt;
  logic          crcDone_r, crcDone_nxt, crc_done_irq_r, crc_done_irq_nxt;

  logic          full, empty, rxTake, firstByte, lenOk, rxWr;
  logic          wrEn, push, pop, hostPop, crcPop;
  logic [7:0]    wrData, headByte;
  logic [8:0]    lenVal, minLen, maxLen;
  logic [CW-1:0] freeSpace;

  function automatic logic [15:0] crcByte(input logic [15:0] c,
                                           input logic [7:0]  d,
                                           input logic        msb);
    logic [15:0] v;
    logic        fb;
    v = c;
    for (int i = 0; i < 8; i++) begin
      if (msb) begin
        fb = v[15] ^ d[7-i];
        v  = {v[14:0], 1'b0} ^ (fb ? `CRC_POLY_MSB : 16'h0000);
      end else begin
        fb = v[0] ^ d[i];
        v  = {1'b0, v[15:1]} ^ (fb ? `CRC_POLY_LSB : 16'h0000);
      end
    end
    return v;
  endfunction

  function automatic logic [15:0] crc_start_sel(input logic [1:0] sel);
    case (sel)
      2'h0:    return `CRC_PRESET_0;
      2'h1:    return `CRC_PRESET_1;
      2'h2:    return `CRC_PRESET_2;
      default: return `CRC_PRESET_3;
    endcase
  endfunction

  always_comb begin
    full      = (count_r == FULL_CNT);
    empty     = (count_r == '0);
    headByte  = mem[rdPtr_r];
    // Length filter works on the first byte alone, so a rejected
    // packet never touches the buffer.
    firstByte = !inPkt_r;
    lenVal    = {1'b0, rxIn.data};
    minLen    = {1'b0, lenFilter.minLenQuads, 2'b00};
    maxLen    = (lenFilter.maxLenQuads == 6'h00) ? `LEN_NO_LIMIT :
                {1'b0, lenFilter.maxLenQuads, 2'b00};
    lenOk     = (lenVal >= minLen) && (lenVal < maxLen);
    rxTake    = rxIn.valid && rxReady_r;
    rxWr      = rxTake && (firstByte ? lenOk : !drop_r);

    inPkt_nxt   = inPkt_r;
    drop_nxt    = drop_r;
    pktErr_nxt  = pktErr_r;
    stsPend_nxt = 1'b0;
    stsByte_nxt = stsByte_r;
    rxDone_nxt  = rxDone_r && rxEnable;
    if (rxTake) begin
      if (rxIn.last) begin
        inPkt_nxt  = 1'b0;
        drop_nxt   = 1'b0;
        pktErr_nxt = 1'b0;
        if (rxWr && multi_packet_rx) begin
          stsPend_nxt = 1'b1;
          stsByte_nxt = (pktErr_r || rxIn.err) ? `RX_STS_ERR : `RX_STS_OK;
        end else if (rxWr) begin
          rxDone_nxt = 1'b1;
        end
      end else begin
        inPkt_nxt  = 1'b1;
        drop_nxt   = firstByte ? !lenOk : drop_r;
        pktErr_nxt = pktErr_r || rxIn.err;
      end
    end
    // Only the status slot costs a cycle of readiness in multi mode.
    rxReady_nxt = rxEnable && !stsPend_nxt && !rxDone_nxt;

    // Device writes win; a colliding host write is the host's fault.
    wrEn   = stsPend_r || rxWr || hostWrStb;
    wrData = stsPend_r ? stsByte_r : (rxWr ? rxIn.data : hostWrData);
    push   = wrEn && !full;
    crcPop  = (crcState_r == CRC_RUN) && !empty;
    hostPop = hostRdStb && !empty && (crcState_r == CRC_IDLE);
    pop     = crcPop || hostPop;

    wrPtr_nxt  = push ? AW'(wrPtr_r + 1'b1) : wrPtr_r;
    rdPtr_nxt  = pop ? AW'(rdPtr_r + 1'b1) : rdPtr_r;
    count_nxt  = CW'(count_r + CW'(push) - CW'(pop));
    ovf_nxt    = ovf_r;
    rdData_nxt = rdData_r;
    if (hostPop) begin
      rdData_nxt = headByte;
    end else if (hostRdStb && empty) begin
      rdData_nxt = `RD_EMPTY_VALUE;
    end
    if (buffer_flush) begin
      wrPtr_nxt = '0;
      rdPtr_nxt = '0;
      count_nxt = '0;
      ovf_nxt   = 1'b0;
    end
    // Set beats the flush clear in the same cycle.
    if (wrEn && full) begin
      ovf_nxt = 1'b1;
    end

    freeSpace     = CW'(FULL_CNT - count_nxt);
    nearFull_nxt  = (freeSpace <= CW'(watermark));
    nearEmpty_nxt = (count_nxt <= CW'(watermark));
    irq_nxt = (near_empty_irq_en && nearEmpty_nxt && !nearEmpty_r) ||
              (near_full_irq_en && nearFull_nxt && !nearFull_r);

    crcState_nxt = crcState_r;
    crc_nxt      = crc_r;
    crcDone_nxt  = crcDone_r;
    crc_done_irq_nxt   = crc_done_irq_r && !crcIrqClr;
    case (crcState_r)
      CRC_IDLE: begin
        if (crcCfg.start) begin
          crcState_nxt = CRC_RUN;
          crc_nxt      = crc_start_sel(crcCfg.startSel);
          crcDone_nxt  = 1'b0;
        end
      end
      CRC_RUN: begin
        if (!empty) begin
          crc_nxt = crcByte(crc_r, headByte, crcCfg.msbOrder);
        end else begin
          crcState_nxt = CRC_IDLE;
          crcDone_nxt  = 1'b1;
          crc_done_irq_nxt   = 1'b1;
        end
      end
      default: crcState_nxt = CRC_IDLE;
    endcase
  end

  // Storage has no reset; flush makes old bytes unreachable instead.
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_r] <= wrData;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_r     <= '0;
      rdPtr_r     <= '0;
      count_r     <= '0;
      ovf_r       <= 1'b0;
      nearFull_r  <= 1'b0;
      nearEmpty_r <= 1'b1;
      irq_r       <= 1'b0;
      rdData_r    <= 8'h00;
      inPkt_r     <= 1'b0;
      drop_r      <= 1'b0;
      pktErr_r    <= 1'b0;
      stsPend_r   <= 1'b0;
      stsByte_r   <= 8'h00;
      rxDone_r    <= 1'b0;
      rxReady_r   <= 1'b0;
      crcState_r  <= CRC_IDLE;
      crc_r       <= 16'h0000;
      crcDone_r   <= 1'b0;
      crc_done_irq_r    <= 1'b0;
    end else begin
      wrPtr_r     <= wrPtr_nxt;
      rdPtr_r     <= rdPtr_nxt;
      count_r     <= count_nxt;
      ovf_r       <= ovf_nxt;
      nearFull_r  <= nearFull_nxt;
      nearEmpty_r <= nearEmpty_nxt;
      irq_r       <= irq_nxt;
      rdData_r    <= rdData_nxt;
      inPkt_r     <= inPkt_nxt;
      drop_r      <= drop_nxt;
      pktErr_r    <= pktErr_nxt;
      stsPend_r   <= stsPend_nxt;
      stsByte_r   <= stsByte_nxt;
      rxDone_r    <= rxDone_nxt;
      rxReady_r   <= rxReady_nxt;
      crcState_r  <= crcState_nxt;
      crc_r       <= crc_nxt;
      crcDone_r   <= crcDone_nxt;
      crc_done_irq_r    <= crc_done_irq_nxt;
    end
  end

  assign hostRdData          = rdData_r;
  assign stored_byte_count   = count_r;
  assign buffer_overflow_err = ovf_r;
  assign near_full_flag      = nearFull_r;
  assign near_empty_flag     = nearEmpty_r;
  assign alertIrq            = irq_r;
  assign rxReady             = rxReady_r;
  assign crcResultHi         = crc_r[15:8];
  assign crcResultLo         = crc_r[7:0];
  assign crc_done            = crcDone_r;
  assign crc_done_irq        = crc_done_irq_r;
  assign crcBusy             = (crcState_r == CRC_RUN);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence seqCrcFinish;
    (crcState_r == CRC_RUN) && empty ##1 (crcState_r == CRC_IDLE);
  endsequence

  sequence seqHostWriteOnly;
    hostWrStb && !full && !stsPend_r && !rxWr && !pop && !buffer_flush;
  endsequence

  AST_LEVEL_BOUND: assert property (count_r <= FULL_CNT)
    else $error("level beyond depth");

  AST_WRITE_INC: assert property (
    seqHostWriteOnly |=> count_r == CW'($past(count_r) + 1'b1) &&
                         wrPtr_r == AW'($past(wrPtr_r) + 1'b1))
    else $error("host write did not advance");

  AST_READ_DATA: assert property (
    hostRdStb && !empty && !crcBusy && !wrEn && !buffer_flush
    |=> hostRdData == $past(headByte) &&
        count_r == CW'($past(count_r) - 1'b1))
    else $error("host read wrong byte or level");

  AST_LEVEL_DIST: assert property (
    !full |-> AW'(wrPtr_r - rdPtr_r) == AW'(count_r))
    else $error("level differs from pointer distance");

  AST_FLUSH: assert property (
    buffer_flush && !(wrEn && full)
    |=> count_r == '0 && wrPtr_r == '0 && rdPtr_r == '0 && !ovf_r)
    else $error("flush incomplete");

  AST_OVF_STICKY: assert property (
    ovf_r && !buffer_flush |=> ovf_r)
    else $error("overflow cleared without flush");

  AST_OVF_SET: assert property (
    wrEn && full && !pop && !buffer_flush |=> ovf_r && count_r == FULL_CNT)
    else $error("overflow not flagged or data kept");

  AST_NEAR_FULL: assert property (
    ##1 $stable(watermark) |->
    nearFull_r == (CW'(FULL_CNT - count_r) <= CW'(watermark)))
    else $error("near-full flag wrong");

  AST_NEAR_EMPTY: assert property (
    ##1 $stable(watermark) |->
    nearEmpty_r == (count_r <= CW'(watermark)))
    else $error("near-empty flag wrong");

  AST_IRQ_LO: assert property (
    near_empty_irq_en && !nearEmpty_r && nearEmpty_nxt |=> alertIrq)
    else $error("near-empty interrupt missing");

  AST_IRQ_HI: assert property (
    near_full_irq_en && !nearFull_r && nearFull_nxt |=> alertIrq)
    else $error("near-full interrupt missing");

  AST_REJECT: assert property (
    rxTake && firstByte && !lenOk && !rxIn.last ##1
    (rxTake && !hostWrStb && !stsPend_r)
    |-> !wrEn)
    else $error("rejected packet byte stored");

  AST_STATUS_APPEND: assert property (
    rxTake && rxIn.last && rxWr && multi_packet_rx
    |=> stsPend_r ##1 rxReady_r || !rxEnable || rxDone_r)
    else $error("status byte or readiness missing");

  AST_CRC_DONE: assert property (
    seqCrcFinish |-> crc_done && crc_done_irq)
    else $error("crc finish not flagged");

  AST_CRC_PRESET: assert property (
    !crcBusy && crcCfg.start && crcCfg.startSel == 2'h1
    |=> crc_r == `CRC_PRESET_1)
    else $error("crc preset wrong");

  AST_EMPTY_READ: assert property (
    hostRdStb && empty && !wrEn && !buffer_flush
    |=> count_r == '0 && rdPtr_r == $past(rdPtr_r))
    else $error("empty read moved pointer");

endmodule

// File: testbench/rx_source.sv
`timescale 1ns/1ps
module rx_source
  import host_fifo_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rxReady,
  output rx_byte_t  rxIn
);
  initial rxIn = '0;

  // Byte held until an edge with rxReady high takes it
  task automatic sendByte(input logic [7:0] d, input logic lst,
                          input logic e);
    int n;
    n = 0;
    @(negedge core_clk);
    rxIn <= '{valid: 1'b1, last: lst, err: e, data: d};
    // Ready only moves on a rising edge; seen here it is what the next
    // edge samples, so the byte is offered to exactly one taking edge
    while (!rxReady && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    @(posedge core_clk);
  endtask

  // Released data shows the inverse, never the old byte
  task automatic idle();
    @(negedge core_clk);
    rxIn <= '{valid: 1'b0, last: 1'b0, err: 1'b0, data: ~rxIn.data};
  endtask
endmodule

// File: testbench/tb_host_fifo_with_crc_and_length_filter.sv
`timescale 1ns/1ps
module tb_host_fifo_with_crc_and_length_filter;
  import host_fifo_pkg::*;
  logic        core_clk = 0;
  logic        rst_n = 0;
  logic        hostWrStb = 0;
  logic [7:0]  hostWrData = '0;
  logic        hostRdStb = 0;
  logic [7:0]  hostRdData;
  logic        buffer_flush = 0;
  logic [5:0]  watermark = 6'h04;
  logic        loIrqEn = 0;
  logic        hiIrqEn = 1;
  logic        rxEnable = 0;
  logic        multiRx = 0;
  len_filter_t lenFilter = '0;
  rx_byte_t    rxIn;
  logic        rxReady;
  crc_cfg_t    crcCfg = '0;
  logic        crcIrqClr = 0;
  logic [6:0]  stored_byte_count;
  logic        buffer_overflow_err;
  logic        near_full_flag;
  logic        near_empty_flag;
  logic        alertIrq;
  logic [7:0]  crcResultHi;
  logic [7:0]  crcResultLo;
  logic        crc_done;
  logic        crc_done_irq;
  logic        crcBusy;
  int          err_total = 0;
  int          cmp_count = 0;
  logic [7:0]  q;

  host_fifo_with_crc_and_length_filter #(.DEPTH(64))
    host_fifo_with_crc_and_length_filter_inst (
    .core_clk(core_clk), .rst_n(rst_n), .hostWrStb(hostWrStb),
    .hostWrData(hostWrData), .hostRdStb(hostRdStb),
    .hostRdData(hostRdData), .buffer_flush(buffer_flush),
    .watermark(watermark), .near_empty_irq_en(loIrqEn),
    .near_full_irq_en(hiIrqEn), .rxEnable(rxEnable),
    .multi_packet_rx(multiRx), .lenFilter(lenFilter), .rxIn(rxIn),
    .rxReady(rxReady), .crcCfg(crcCfg), .crcIrqClr(crcIrqClr),
    .stored_byte_count(stored_byte_count),
    .buffer_overflow_err(buffer_overflow_err),
    .near_full_flag(near_full_flag), .near_empty_flag(near_empty_flag),
    .alertIrq(alertIrq), .crcResultHi(crcResultHi),
    .crcResultLo(crcResultLo), .crc_done(crc_done),
    .crc_done_irq(crc_done_irq), .crcBusy(crcBusy));

  rx_source rx_source_inst (
    .core_clk(core_clk), .rxReady(rxReady), .rxIn(rxIn));

  always #5 core_clk = ~core_clk;

  task automatic chk(input string nm, input logic [15:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] d);
    @(negedge core_clk);
    hostWrStb = 1;
    hostWrData = d;
    @(negedge core_clk);
    hostWrStb = 0;
  endtask

  task automatic rd(output logic [7:0] d);
    @(negedge core_clk);
    hostRdStb = 1;
    @(negedge core_clk);
    hostRdStb = 0;
    d = hostRdData;
  endtask

  task automatic flush();
    @(negedge core_clk);
    buffer_flush = 1;
    @(negedge core_clk);
    buffer_flush = 0;
  endtask

  function automatic logic [15:0] crcRef(input logic [15:0] c,
                                         input logic [7:0] d,
                                         input logic msb);
    for (int i = 0; i < 8; i++) begin
      if (msb)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ d[7-i]) ? 16'h1021 : 16'h0);
      else
        c = (c >> 1) ^ ((c[0] ^ d[i]) ? 16'h8408 : 16'h0);
    end
    return c;
  endfunction

  task automatic t_fill();
    for (int i = 0; i < 64; i++) begin
      wr(i[7:0]);
      if (i == 58) chk("nearFull59", near_full_flag, 0);
      if (i == 59) chk("nearFull60", near_full_flag, 1);
      if (i == 59) chk("hiIrq", alertIrq, 1);
    end
    chk("count64", stored_byte_count, 64);
    wr(8'hee);
    chk("ovfl", buffer_overflow_err, 1);
    chk("countFull", stored_byte_count, 64);
    rd(q);
    chk("head0", q, 8'h00);
    rd(q);
    chk("head1", q, 8'h01);
    chk("count62", stored_byte_count, 62);
    chk("ovflSticky", buffer_overflow_err, 1);
    flush();
    chk("flushCount", stored_byte_count, 0);
    chk("flushOvfl", buffer_overflow_err, 0);
    rd(q);
    chk("emptyRd", q, 8'h00);
    chk("emptyCount", stored_byte_count, 0);
    wr(8'h5a);
    rd(q);
    chk("afterFlush", q, 8'h5a);
    $display("test fill done");
  endtask

  task automatic t_low();
    watermark = 6'h02;
    hiIrqEn = 0;
    loIrqEn = 1;
    for (int i = 0; i < 3; i++) wr(8'h10 + i[7:0]);
    chk("nearEmpty3", near_empty_flag, 0);
    rd(q);
    chk("nearEmpty2", near_empty_flag, 1);
    chk("loIrq", alertIrq, 1);
    flush();
    $display("test low alert done");
  endtask

  task automatic t_rx();
    logic [7:0] lens[5] = '{8'h03, 8'h04, 8'h07, 8'h08, 8'hff};
    logic [7:0] exp[9] = '{8'h04, 8'ha1, 8'h00, 8'h07, 8'ha2, 8'h01,
                          8'hff, 8'ha4, 8'h00};
    rxEnable = 1;
    multiRx = 1;
    lenFilter = '{minLenQuads: 6'd1, maxLenQuads: 6'd2};
    for (int i = 0; i < 5; i++) begin
      if (i == 4) begin
        rx_source_inst.idle();
        lenFilter = '0;
      end
      rx_source_inst.sendByte(lens[i], 1'b0, 1'b0);
      rx_source_inst.sendByte(8'ha0 + i[7:0], 1'b1, i == 2);
    end
    rx_source_inst.idle();
    chk("rxGap", rxReady, 0);
    @(negedge core_clk);
    chk("rxAgain", rxReady, 1);
    repeat (2) @(negedge core_clk);
    chk("rxCount", stored_byte_count, 9);
    for (int i = 0; i < 9; i++) begin
      rd(q);
      chk("rxByte", q, exp[i]);
    end
    // Single-packet mode: no status byte, receiver stops after one packet
    multiRx = 0;
    rx_source_inst.sendByte(8'h02, 1'b0, 1'b0);
    rx_source_inst.sendByte(8'hb0, 1'b1, 1'b0);
    rx_source_inst.idle();
    chk("rxStop", rxReady, 0);
    @(negedge core_clk);
    chk("rxSingle", stored_byte_count, 2);
    flush();
    rxEnable = 0;
    $display("test receive done");
  endtask

  task automatic t_crc();
    logic [15:0] pre[4] = '{16'h0000, 16'h6363, 16'ha671, 16'hffff};
    logic [15:0] c;
    int n;
    for (int s = 0; s < 4; s++) begin
      wr(8'h12);
      wr(8'h34);
      c = crcRef(crcRef(pre[s], 8'h12, s[0]), 8'h34, s[0]);
      @(negedge core_clk);
      crcCfg = '{start: 1'b1, startSel: s[1:0], msbOrder: s[0]};
      @(negedge core_clk);
      crcCfg.start = 0;
      chk("crcBusy", crcBusy, 1);
      n = 0;
      // No host reads while the CRC drains the buffer
      while (!crc_done && n < 100) begin
        @(negedge core_clk);
        n++;
      end
      chk("crcDone", crc_done, 1);
      chk("crcIdle", crcBusy, 0);
      chk("crcHi", crcResultHi, c[15:8]);
      chk("crcLo", crcResultLo, c[7:0]);
      chk("crc_done_irq", crc_done_irq, 1);
      chk("crcDrain", stored_byte_count, 0);
      @(negedge core_clk);
      crcIrqClr = 1;
      @(negedge core_clk);
      crcIrqClr = 0;
      chk("crcIrqClr", crc_done_irq, 0);
    end
    $display("test crc done");
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    #100000;
    err_total++;
    complete_run();
  end

  initial begin
    repeat (8) @(negedge core_clk);
    rst_n = 1;
    chk("rstCount", stored_byte_count, 0);
    chk("rstEmpty", near_empty_flag, 1);
    t_fill();
    t_low();
    t_rx();
    t_crc();
    complete_run();
  end
endmodule
